// *** design/jsdr_scan_chains.sv ***
// instruction decode and data chains of the serial test port, with pad muxing
`timescale 1ns/1ps
// Behaviour
// [RULE1] sample/preload routes boundary chain through
// [RULE2] capture loads pad input, output, enable
// [RULE3] shift-dr moves samples out, preload in
// [RULE4] entering update-dr copies chain to holding
// [RULE5] holding values force extest and intest data
// [RULE6] chain starts nearest pad: in, out, enable
// [RULE7] exactly six data chains exist
// [RULE8] abort selects 35-bit chain to port
// [RULE9] debug-port chain: 35-bit register requests
// [RULE10] access-port chain: 35-bit bus requests
// [RULE11] identification selects fixed 32-bit code
// [RULE12] resets and test-logic-reset force identification
// [RULE13] identification captured value ends in one
// [RULE14] bypass is one flop, shortest path
// [RULE15] bypass flop captures zero
// [RULE16] 4-bit instruction codes as listed
// [RULE17] unassigned codes behave as bypass
// [RULE18] extest drives pads from holding values
// [RULE19] intest drives core inputs; reset observe-only
// [RULE20] sixteen-state controller, output only while shifting
module jsdr_scan_chains #(
  parameter int NUM_PADS = 8,
  // arbitrary value, only its lowest bit is fixed
  parameter logic [jsdr_pkg::ID_W-1:0] ID_CODE = 32'h1234_5679
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic test_rst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [NUM_PADS-1:0] pad_in,
  input wire logic rst_pin_n,
  input wire logic [NUM_PADS-1:0] core_out,
  input wire logic [NUM_PADS-1:0] core_oe,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe,
  output logic [NUM_PADS-1:0] core_in,
  input wire logic [jsdr_pkg::DBG_W-1:0] dbg_rsp_word,
  output logic dbg_req_valid,
  output logic [jsdr_pkg::DBG_SEL_W-1:0] dbg_req_sel,
  output logic [jsdr_pkg::DBG_W-1:0] dbg_req_word
);
  localparam int CPP = jsdr_pkg::CELLS_PER_PAD;
  localparam int HW = CPP * NUM_PADS;
  localparam int BW = HW + 1;

  typedef struct packed {
    jsdr_pkg::jsdr_tap_type state;
    logic [jsdr_pkg::IR_W-1:0] ir_shift;
    logic [jsdr_pkg::IR_W-1:0] ir;
    logic byp;
    logic [jsdr_pkg::ID_W-1:0] idr;
    logic [BW-1:0] bsr;
    logic [HW-1:0] hold;
    logic [jsdr_pkg::DBG_W-1:0] dbg;
    logic dbg_go;
    logic [jsdr_pkg::DBG_SEL_W-1:0] dbg_sel;
    logic [jsdr_pkg::DBG_W-1:0] dbg_word;
    logic ext;
    logic inte;
    logic tdo;
    logic tdo_oe;
  } jsdr_tck_state_type;

  typedef struct packed {
    logic [NUM_PADS-1:0] pad_out;
    logic [NUM_PADS-1:0] pad_oe;
    logic [NUM_PADS-1:0] core_in;
  } jsdr_sys_state_type;

  jsdr_tck_state_type t;
  jsdr_tck_state_type next_t;
  jsdr_sys_state_type c;
  jsdr_sys_state_type next_c;
  jsdr_pkg::jsdr_chain_type ch;

  logic [1:0] rst_s;
  logic tck_rst;
  logic [BW-1:0] cap_raw;
  logic [BW-1:0] cap_s;
  logic [jsdr_pkg::DBG_W-1:0] rsp_s;
  logic [HW+1:0] hold_s;
  logic ext_s;
  logic inte_s;
  logic [NUM_PADS-1:0] padin_s;
  logic [NUM_PADS-1:0] hold_in_s;
  logic [NUM_PADS-1:0] hold_out_s;
  logic [NUM_PADS-1:0] hold_oe_s;

  // power-on reset and the test reset pin both reach the test clock domain
  jsdr_sync #(.WIDTH(2)) u_rst_sync (
    .clock(tck),
    .d({sys_rst, ~test_rst_n}),
    .q(rst_s)
  );
  assign tck_rst = rst_s[0] | rst_s[1]; // RULE12

  // pad 0 sits nearest the port pins and is shifted out first
  genvar p;
  generate
    for (p = 0; p < NUM_PADS; p++) begin : g_cells
      assign cap_raw[p*CPP+jsdr_pkg::CELL_IN] = pad_in[p]; // RULE6
      assign cap_raw[p*CPP+jsdr_pkg::CELL_OUT] = core_out[p];
      assign cap_raw[p*CPP+jsdr_pkg::CELL_OE] = core_oe[p];
      assign hold_in_s[p] = hold_s[p*CPP+jsdr_pkg::CELL_IN];
      assign hold_out_s[p] = hold_s[p*CPP+jsdr_pkg::CELL_OUT];
      assign hold_oe_s[p] = hold_s[p*CPP+jsdr_pkg::CELL_OE];
    end
  endgenerate
  // the reset pin cell is observed only and has no holding bit
  assign cap_raw[BW-1] = rst_pin_n; // RULE19

  // samples are not coherent across bits; pads are asynchronous anyway
  jsdr_sync #(.WIDTH(BW)) u_cap_sync (
    .clock(tck),
    .d(cap_raw),
    .q(cap_s)
  );

  // response word must be held steady by the port logic between requests
  jsdr_sync #(.WIDTH(jsdr_pkg::DBG_W)) u_rsp_sync (
    .clock(tck),
    .d(dbg_rsp_word),
    .q(rsp_s)
  );

  assign ch = jsdr_pkg::jsdr_chain_of(t.ir); // RULE17

  always_comb begin
    next_t = t;
    next_t.dbg_go = 1'b0;
    case (t.state) // RULE20
      jsdr_pkg::TAP_TLR: next_t.state = tms ? jsdr_pkg::TAP_TLR : jsdr_pkg::TAP_IDLE;
      jsdr_pkg::TAP_IDLE: next_t.state = tms ? jsdr_pkg::TAP_SEL_DR : jsdr_pkg::TAP_IDLE;
      jsdr_pkg::TAP_SEL_DR: next_t.state = tms ? jsdr_pkg::TAP_SEL_IR : jsdr_pkg::TAP_CAP_DR;
      jsdr_pkg::TAP_CAP_DR: next_t.state = tms ? jsdr_pkg::TAP_EXIT1_DR : jsdr_pkg::TAP_SHIFT_DR;
      jsdr_pkg::TAP_SHIFT_DR: next_t.state = tms ? jsdr_pkg::TAP_EXIT1_DR : jsdr_pkg::TAP_SHIFT_DR;
      jsdr_pkg::TAP_EXIT1_DR: next_t.state = tms ? jsdr_pkg::TAP_UPD_DR : jsdr_pkg::TAP_PAUSE_DR;
      jsdr_pkg::TAP_PAUSE_DR: next_t.state = tms ? jsdr_pkg::TAP_EXIT2_DR : jsdr_pkg::TAP_PAUSE_DR;
      jsdr_pkg::TAP_EXIT2_DR: next_t.state = tms ? jsdr_pkg::TAP_UPD_DR : jsdr_pkg::TAP_SHIFT_DR;
      jsdr_pkg::TAP_UPD_DR: next_t.state = tms ? jsdr_pkg::TAP_SEL_DR : jsdr_pkg::TAP_IDLE;
      jsdr_pkg::TAP_SEL_IR: next_t.state = tms ? jsdr_pkg::TAP_TLR : jsdr_pkg::TAP_CAP_IR;
      jsdr_pkg::TAP_CAP_IR: next_t.state = tms ? jsdr_pkg::TAP_EXIT1_IR : jsdr_pkg::TAP_SHIFT_IR;
      jsdr_pkg::TAP_SHIFT_IR: next_t.state = tms ? jsdr_pkg::TAP_EXIT1_IR : jsdr_pkg::TAP_SHIFT_IR;
      jsdr_pkg::TAP_EXIT1_IR: next_t.state = tms ? jsdr_pkg::TAP_UPD_IR : jsdr_pkg::TAP_PAUSE_IR;
      jsdr_pkg::TAP_PAUSE_IR: next_t.state = tms ? jsdr_pkg::TAP_EXIT2_IR : jsdr_pkg::TAP_PAUSE_IR;
      jsdr_pkg::TAP_EXIT2_IR: next_t.state = tms ? jsdr_pkg::TAP_UPD_IR : jsdr_pkg::TAP_SHIFT_IR;
      jsdr_pkg::TAP_UPD_IR: next_t.state = tms ? jsdr_pkg::TAP_SEL_DR : jsdr_pkg::TAP_IDLE;
      default: next_t.state = jsdr_pkg::TAP_TLR;
    endcase

    case (t.state)
      jsdr_pkg::TAP_TLR: next_t.ir = jsdr_pkg::IR_IDENT; // RULE12
      jsdr_pkg::TAP_CAP_IR: next_t.ir_shift = jsdr_pkg::IR_CAPTURE;
      jsdr_pkg::TAP_SHIFT_IR: next_t.ir_shift = {tdi, t.ir_shift[jsdr_pkg::IR_W-1:1]};
      jsdr_pkg::TAP_CAP_DR: begin
        case (ch) // RULE7
          jsdr_pkg::CH_IDENT: next_t.idr = {ID_CODE[jsdr_pkg::ID_W-1:1], 1'b1}; // RULE11 RULE13
          jsdr_pkg::CH_BOUND: next_t.bsr = cap_s; // RULE2
          jsdr_pkg::CH_ABORT, jsdr_pkg::CH_DP_ACCESS, jsdr_pkg::CH_AP_ACCESS: begin
            next_t.dbg = rsp_s; // RULE9
          end
          default: next_t.byp = 1'b0; // RULE15
        endcase
      end
      jsdr_pkg::TAP_SHIFT_DR: begin
        case (ch)
          jsdr_pkg::CH_IDENT: next_t.idr = {tdi, t.idr[jsdr_pkg::ID_W-1:1]};
          jsdr_pkg::CH_BOUND: next_t.bsr = {tdi, t.bsr[BW-1:1]}; // RULE1 RULE3
          jsdr_pkg::CH_ABORT, jsdr_pkg::CH_DP_ACCESS, jsdr_pkg::CH_AP_ACCESS: begin
            next_t.dbg = {tdi, t.dbg[jsdr_pkg::DBG_W-1:1]};
          end
          default: next_t.byp = tdi; // RULE14
        endcase
      end
      default: ;
    endcase

    // holding registers change on the edge that enters update
    if (next_t.state == jsdr_pkg::TAP_UPD_IR) begin
      next_t.ir = t.ir_shift; // RULE16
    end
    if (next_t.state == jsdr_pkg::TAP_UPD_DR) begin
      case (ch)
        jsdr_pkg::CH_BOUND: next_t.hold = t.bsr[HW-1:0]; // RULE4
        jsdr_pkg::CH_ABORT: begin
          next_t.dbg_go = 1'b1; // RULE8
          next_t.dbg_sel = jsdr_pkg::DBG_SEL_ABORT;
          next_t.dbg_word = t.dbg;
        end
        jsdr_pkg::CH_DP_ACCESS: begin
          next_t.dbg_go = 1'b1; // RULE9
          next_t.dbg_sel = jsdr_pkg::DBG_SEL_DP;
          next_t.dbg_word = t.dbg;
        end
        jsdr_pkg::CH_AP_ACCESS: begin
          next_t.dbg_go = 1'b1; // RULE10
          next_t.dbg_sel = jsdr_pkg::DBG_SEL_AP;
          next_t.dbg_word = t.dbg;
        end
        default: ;
      endcase
    end

    if (tck_rst) begin
      next_t = '0;
      next_t.state = jsdr_pkg::TAP_TLR;
      next_t.ir = jsdr_pkg::IR_IDENT; // RULE12
    end

    next_t.ext = (next_t.ir == jsdr_pkg::IR_EXTEST);
    next_t.inte = (next_t.ir == jsdr_pkg::IR_INTEST);
    // the output is set up one edge early, so the tester samples it on its rising edge
    next_t.tdo_oe = (next_t.state == jsdr_pkg::TAP_SHIFT_DR) ||
                    (next_t.state == jsdr_pkg::TAP_SHIFT_IR); // RULE20
    if (next_t.state == jsdr_pkg::TAP_SHIFT_IR) begin
      next_t.tdo = next_t.ir_shift[0];
    end else begin
      case (ch)
        jsdr_pkg::CH_IDENT: next_t.tdo = next_t.idr[0];
        jsdr_pkg::CH_BOUND: next_t.tdo = next_t.bsr[0]; // RULE1
        jsdr_pkg::CH_ABORT, jsdr_pkg::CH_DP_ACCESS, jsdr_pkg::CH_AP_ACCESS: begin
          next_t.tdo = next_t.dbg[0];
        end
        default: next_t.tdo = next_t.byp; // RULE17
      endcase
    end
  end

  always_ff @(posedge tck) begin
    t <= next_t;
  end

  assign tdo = t.tdo;
  assign tdo_oe = t.tdo_oe;

  // launched on the update edge itself, so a tester that stops its clock there still issues it
  jsdr_word_xfer #(.WIDTH(jsdr_pkg::DBG_SEL_W + jsdr_pkg::DBG_W)) u_dbg_xfer (
    .src_clock(tck),
    .src_rst(tck_rst),
    .src_valid(next_t.dbg_go),
    .src_word({next_t.dbg_sel, next_t.dbg_word}),
    .dst_clock(clock),
    .dst_rst(sys_rst),
    .dst_valid(dbg_req_valid),
    .dst_word({dbg_req_sel, dbg_req_word})
  );

  // holding values and mode are quasi-static while a test is set up
  jsdr_sync #(.WIDTH(HW + 2)) u_hold_sync (
    .clock(clock),
    .d({t.inte, t.ext, t.hold}),
    .q(hold_s)
  );
  assign ext_s = hold_s[HW];
  assign inte_s = hold_s[HW+1];

  jsdr_sync #(.WIDTH(NUM_PADS)) u_padin_sync (
    .clock(clock),
    .d(pad_in),
    .q(padin_s)
  );

  always_comb begin
    next_c.pad_out = ext_s ? hold_out_s : core_out; // RULE5 RULE18
    next_c.pad_oe = ext_s ? hold_oe_s : core_oe; // RULE18
    next_c.core_in = inte_s ? hold_in_s : padin_s; // RULE5 RULE19
    if (sys_rst) begin
      next_c = '0;
    end
  end

  always_ff @(posedge clock) begin
    c <= next_c;
  end

  assign pad_out = c.pad_out;
  assign pad_oe = c.pad_oe;
  assign core_in = c.core_in;

  property p_ir_reset;
    @(posedge tck) $fell(tck_rst) |-> t.ir == jsdr_pkg::IR_IDENT;
  endproperty
  a_ir_reset: assert property (p_ir_reset) else $error("ir not ident after reset"); // RULE12

  property p_tlr_ident;
    @(posedge tck) disable iff (tck_rst)
      t.state == jsdr_pkg::TAP_TLR |=> t.ir == jsdr_pkg::IR_IDENT;
  endproperty
  a_tlr_ident: assert property (p_tlr_ident) else $error("ir not ident in reset state"); // RULE12

  property p_ident_lsb;
    @(posedge tck) disable iff (tck_rst)
      (t.state == jsdr_pkg::TAP_CAP_DR && ch == jsdr_pkg::CH_IDENT)
      |=> t.idr[0] == 1'b1 && t.idr == ID_CODE;
  endproperty
  a_ident_lsb: assert property (p_ident_lsb) else $error("ident capture wrong"); // RULE13

  property p_bypass_zero;
    @(posedge tck) disable iff (tck_rst)
      (t.state == jsdr_pkg::TAP_CAP_DR && ch == jsdr_pkg::CH_BYPASS)
      ##1 (t.state == jsdr_pkg::TAP_SHIFT_DR) |-> t.tdo == 1'b0 && t.tdo_oe;
  endproperty
  a_bypass_zero: assert property (p_bypass_zero) else $error("bypass first bit not zero"); // RULE15

  property p_bypass_path;
    @(posedge tck) disable iff (tck_rst)
      (t.state == jsdr_pkg::TAP_SHIFT_DR && ch == jsdr_pkg::CH_BYPASS && !tms)
      |=> t.tdo == $past(tdi);
  endproperty
  a_bypass_path: assert property (p_bypass_path) else $error("bypass path not one flop"); // RULE17

  property p_tdo_shift_only;
    @(posedge tck) disable iff (tck_rst)
      t.tdo_oe |-> (t.state == jsdr_pkg::TAP_SHIFT_DR || t.state == jsdr_pkg::TAP_SHIFT_IR);
  endproperty
  a_tdo_shift_only: assert property (p_tdo_shift_only) else $error("tdo driven out of shift"); // RULE20

  property p_bound_capture;
    @(posedge tck) disable iff (tck_rst)
      (t.state == jsdr_pkg::TAP_CAP_DR && ch == jsdr_pkg::CH_BOUND) |=> t.bsr == $past(cap_s);
  endproperty
  a_bound_capture: assert property (p_bound_capture) else $error("boundary capture missed"); // RULE2

  property p_bound_shift;
    @(posedge tck) disable iff (tck_rst)
      (t.state == jsdr_pkg::TAP_SHIFT_DR && ch == jsdr_pkg::CH_BOUND)
      |=> t.bsr[BW-1] == $past(tdi) && t.bsr[BW-2:0] == $past(t.bsr[BW-1:1]);
  endproperty
  a_bound_shift: assert property (p_bound_shift) else $error("boundary shift wrong"); // RULE3

  property p_bound_update;
    @(posedge tck) disable iff (tck_rst)
      (t.state == jsdr_pkg::TAP_EXIT1_DR && tms && ch == jsdr_pkg::CH_BOUND)
      |=> t.state == jsdr_pkg::TAP_UPD_DR && t.hold == $past(t.bsr[HW-1:0]);
  endproperty
  a_bound_update: assert property (p_bound_update) else $error("holding not updated"); // RULE4

  property p_dbg_request;
    @(posedge tck) disable iff (tck_rst)
      (t.state == jsdr_pkg::TAP_EXIT1_DR && tms && ch == jsdr_pkg::CH_DP_ACCESS)
      |=> t.dbg_go && t.dbg_sel == jsdr_pkg::DBG_SEL_DP ##1 !t.dbg_go;
  endproperty
  a_dbg_request: assert property (p_dbg_request) else $error("debug request not issued"); // RULE9

  property p_extest_drive;
    @(posedge clock) disable iff (sys_rst)
      ext_s |=> c.pad_out == $past(hold_out_s) && c.pad_oe == $past(hold_oe_s);
  endproperty
  a_extest_drive: assert property (p_extest_drive) else $error("extest not driving pads"); // RULE18

  c_ident_capture: cover property (@(posedge tck) disable iff (tck_rst)
    t.state == jsdr_pkg::TAP_CAP_DR && ch == jsdr_pkg::CH_IDENT);
  c_bound_update: cover property (@(posedge tck) disable iff (tck_rst)
    t.state == jsdr_pkg::TAP_UPD_DR && ch == jsdr_pkg::CH_BOUND);
  c_dbg_go: cover property (@(posedge tck) disable iff (tck_rst) t.dbg_go);
  c_extest: cover property (@(posedge clock) disable iff (sys_rst) ext_s);
endmodule

// *** common/jsdr_pkg.sv ***
// shared constants, encodings and decode for the test port data chains
package jsdr_pkg;
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int DBG_W = 35;
  localparam int DBG_SEL_W = 2;
  localparam int CELLS_PER_PAD = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;

  localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] IR_INTEST = 4'h1;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
  localparam logic [IR_W-1:0] IR_ABORT = 4'h8;
  localparam logic [IR_W-1:0] IR_DP_ACCESS = 4'ha;
  localparam logic [IR_W-1:0] IR_AP_ACCESS = 4'hb;
  localparam logic [IR_W-1:0] IR_IDENT = 4'he;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  // fixed pattern loaded into the instruction shifter in capture
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  localparam logic [DBG_SEL_W-1:0] DBG_SEL_ABORT = 2'h0;
  localparam logic [DBG_SEL_W-1:0] DBG_SEL_DP = 2'h1;
  localparam logic [DBG_SEL_W-1:0] DBG_SEL_AP = 2'h2;

  typedef enum logic [3:0] {
    TAP_TLR, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jsdr_tap_type;

  typedef enum logic [2:0] {
    CH_BYPASS, CH_IDENT, CH_BOUND, CH_ABORT, CH_DP_ACCESS, CH_AP_ACCESS
  } jsdr_chain_type;

  function automatic jsdr_chain_type jsdr_chain_of(input logic [IR_W-1:0] ir);
    jsdr_chain_type ch;
    case (ir)
      IR_EXTEST, IR_INTEST, IR_SAMPLE: ch = CH_BOUND;
      IR_ABORT: ch = CH_ABORT;
      IR_DP_ACCESS: ch = CH_DP_ACCESS;
      IR_AP_ACCESS: ch = CH_AP_ACCESS;
      IR_IDENT: ch = CH_IDENT;
      default: ch = CH_BYPASS;
    endcase
    return ch;
  endfunction
endpackage

// *** design/jsdr_sync.sv ***
// two-stage level synchroniser, one pair of flops per bit
`timescale 1ns/1ps
module jsdr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } jsdr_sync_state_type;

  jsdr_sync_state_type s;
  jsdr_sync_state_type next_s;

  // the first stage feeds only the second; no reset so nothing can load it
  always_comb begin
    next_s.meta = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clock) begin
    s <= next_s;
  end

  assign q = s.stable;
endmodule

// *** design/jsdr_word_xfer.sv ***
// toggle handshake carrying a held word from the test clock to the system clock
`timescale 1ns/1ps
module jsdr_word_xfer #(
  parameter int WIDTH = 8
) (
  input wire logic src_clock,
  input wire logic src_rst,
  input wire logic src_valid,
  input wire logic [WIDTH-1:0] src_word,
  input wire logic dst_clock,
  input wire logic dst_rst,
  output logic dst_valid,
  output logic [WIDTH-1:0] dst_word
);
  typedef struct packed {
    logic toggle;
    logic [WIDTH-1:0] word;
  } jsdr_xfer_src_type;

  typedef struct packed {
    logic meta;
    logic stable;
    logic seen;
    logic valid;
    logic [WIDTH-1:0] word;
  } jsdr_xfer_dst_type;

  jsdr_xfer_src_type src;
  jsdr_xfer_src_type next_src;
  jsdr_xfer_dst_type dst;
  jsdr_xfer_dst_type next_dst;

  // the word is held until the next request, far longer than the sync delay
  always_comb begin
    next_src = src;
    if (src_valid) begin
      next_src.toggle = ~src.toggle;
      next_src.word = src_word;
    end
    if (src_rst) begin
      next_src = '0;
    end
  end

  always_ff @(posedge src_clock) begin
    src <= next_src;
  end

  always_comb begin
    next_dst = dst;
    next_dst.meta = src.toggle;
    next_dst.stable = dst.meta;
    next_dst.seen = dst.stable;
    next_dst.valid = dst.stable ^ dst.seen;
    if (dst.stable ^ dst.seen) begin
      next_dst.word = src.word;
    end
    if (dst_rst) begin
      next_dst = '0;
    end
  end

  always_ff @(posedge dst_clock) begin
    dst <= next_dst;
  end

  assign dst_valid = dst.valid;
  assign dst_word = dst.word;
endmodule

// *** tb/jsdr_tester.sv ***
// tester model: drives the test clock, mode select, data in and test reset
`timescale 1ns/1ps
module jsdr_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic test_rst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic oe_seen;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    test_rst_n = 1'b1;
    oe_seen = 1'b0;
  end
  // clock stands low between frames; tms and tdi move only while it is low
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    #16 tck = 1'b1;
    #16 tck = 1'b0;
  endtask
  // five edges of tms high, or the reset pin with tms low, then settle in idle
  task automatic to_idle(input logic pin);
    test_rst_n = ~pin;
    repeat (5) tick(~pin, 1'b0);
    test_rst_n = 1'b1;
    repeat (3) tick(1'b0, 1'b0);
  endtask
  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    dout = '0;
    oe_seen = 1'b1;
    #($urandom_range(1, 7));
    tick(1'b1, 1'b0);
    if (ir)
      tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      // tdo was launched on the previous rise, so read it before this one
      dout[i] = tdo;
      oe_seen &= tdo_oe;
      tick(i == n - 1, din[i]);
    end
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask
endmodule

// *** tb/jsdr_scan_chains_tb.sv ***
// self-checking bench for the test port data chains
`timescale 1ns/1ps
module jsdr_scan_chains_tb;
  localparam int NP = 8;
  localparam int BW = 3 * NP + 1;
  // arbitrary identification value, only the lsb is fixed at one
  localparam logic [31:0] TB_ID = 32'h0c3a_5e97;
  logic clock, sys_rst, tck, tms, tdi, test_rst_n, tdo, tdo_oe, rst_pin_n;
  logic [NP-1:0] pad_in, core_out, core_oe, pad_out, pad_oe, core_in;
  logic [jsdr_pkg::DBG_W-1:0] dbg_rsp_word, dbg_req_word;
  logic dbg_req_valid;
  logic [jsdr_pkg::DBG_SEL_W-1:0] dbg_req_sel;
  logic [63:0] so, si;
  logic [BW-1:0] hold;
  logic [3:0] dbg_ir [3] = '{jsdr_pkg::IR_ABORT, jsdr_pkg::IR_DP_ACCESS, jsdr_pkg::IR_AP_ACCESS};
  int error_cnt = 0, n_checks = 0, cycles = 0, req_cnt = 0, n0;

  jsdr_scan_chains #(.NUM_PADS(NP), .ID_CODE(TB_ID)) uut (.clock(clock), .sys_rst(sys_rst),
    .tck(tck), .tms(tms), .tdi(tdi), .test_rst_n(test_rst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .pad_in(pad_in), .rst_pin_n(rst_pin_n), .core_out(core_out), .core_oe(core_oe),
    .pad_out(pad_out), .pad_oe(pad_oe), .core_in(core_in), .dbg_rsp_word(dbg_rsp_word),
    .dbg_req_valid(dbg_req_valid), .dbg_req_sel(dbg_req_sel), .dbg_req_word(dbg_req_word));
  jsdr_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .test_rst_n(test_rst_n),
    .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // request pulses last one clock, so count them here rather than in the scan
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (dbg_req_valid === 1'b1)
      req_cnt <= req_cnt + 1;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sc(input logic ir, input int n, input logic [63:0] din);
    tester.scan(ir, n, din, so);
    chk({63'h0, tester.oe_seen & ~tdo_oe}, 64'h1);
  endtask

  task automatic load_ir(input logic [3:0] code);
    sc(1'b1, 4, {60'h0, code});
    chk(so, 64'h1);
  endtask

  task automatic drive_pads();
    @(negedge clock);
    pad_in = NP'($urandom);
    core_out = NP'($urandom);
    core_oe = NP'($urandom);
    rst_pin_n = 1'($urandom);
    dbg_rsp_word = 35'({$urandom, $urandom});
    repeat (8) @(posedge clock);
  endtask

  function automatic logic [BW-1:0] bound_exp();
    logic [BW-1:0] v;
    for (int p = 0; p < NP; p++)
      v[3*p +: 3] = {core_oe[p], core_out[p], pad_in[p]};
    v[BW-1] = rst_pin_n;
    return v;
  endfunction

  function automatic logic [NP-1:0] pick(input int off);
    logic [NP-1:0] v;
    for (int p = 0; p < NP; p++)
      v[p] = hold[3*p+off];
    return v;
  endfunction

  initial begin
    void'($urandom(32'h2741));
    sys_rst = 1'b1;
    {pad_in, core_out, core_oe, rst_pin_n, dbg_rsp_word} = '0;
    // the test clock domain needs its own edges to see the reset
    repeat (4) tester.tick(1'b1, 1'b0);
    @(negedge clock);
    sys_rst = 1'b0;
    tester.to_idle(1'b0);
    sc(1'b0, 32, {$urandom, $urandom});
    chk(so, {32'h0, TB_ID});
    $display("test ident done");
    for (int c = 0; c < 16; c++) begin
      if (!(c inside {0, 1, 2, 8, 10, 11, 14})) begin
        load_ir(4'(c));
        si = {$urandom, $urandom};
        sc(1'b0, 8, si);
        chk(so[7:0], {si[6:0], 1'b0});
      end
    end
    $display("test bypass done");
    for (int pin = 0; pin < 2; pin++) begin
      load_ir(jsdr_pkg::IR_BYPASS);
      tester.to_idle(1'(pin));
      sc(1'b0, 32, 64'h0);
      chk(so, {32'h0, TB_ID});
    end
    $display("test reset paths done");
    drive_pads();
    load_ir(jsdr_pkg::IR_SAMPLE);
    hold = BW'({$urandom, $urandom});
    sc(1'b0, BW, 64'(hold));
    chk(so, 64'(bound_exp()));
    chk({pad_out, pad_oe, core_in}, {core_out, core_oe, pad_in});
    $display("test sample done");
    load_ir(jsdr_pkg::IR_EXTEST);
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk({pad_out, pad_oe, core_in}, {pick(1), pick(2), pad_in});
    load_ir(jsdr_pkg::IR_INTEST);
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk({pad_out, pad_oe, core_in}, {core_out, core_oe, pick(0)});
    $display("test forced data done");
    for (int i = 0; i < 3; i++) begin
      drive_pads();
      load_ir(dbg_ir[i]);
      n0 = req_cnt;
      si = {$urandom, $urandom};
      sc(1'b0, 35, si);
      repeat (12) @(posedge clock);
      chk(so, 64'(dbg_rsp_word));
      chk(req_cnt - n0, 64'h1);
      chk({dbg_req_sel, dbg_req_word}, {2'(i), si[34:0]});
    end
    $display("test debug chains done");
    give_verdict();
  end
endmodule
